// ===== src/addr_matcher.sv
// Single 16-bit comparator with bitwise match against a stored value
module addr_matcher (
   // Stored value and observed bus
   input  wire logic [15:0] match_value,
   input  wire logic [15:0] bus_value,
   input  wire logic        enable,
   // Result
   output      logic        hit
);
   logic [15:0] bit_ok;

   genvar i;
   generate
      for (i = 0; i < 16; i++) begin : g_bit
         assign bit_ok[i] = (match_value[i] == bus_value[i]); // [RULE6]
      end
   endgenerate

   assign hit = enable & (&bit_ok);
endmodule : addr_matcher

// ===== src/dbg_cmp_pkg.sv
// Package: register map, reset values, trace storage sizes and reset-hold states of the compare and trace read block
package dbg_cmp_pkg;

   // ------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------
   localparam logic [3:0] OFF_CMP_A_LOW  = 4'h1;
   localparam logic [3:0] OFF_CMP_B_HIGH = 4'h2;
   localparam logic [3:0] OFF_CMP_B_LOW  = 4'h3;
   localparam logic [3:0] OFF_CMP_C_HIGH = 4'h4;
   localparam logic [3:0] OFF_CMP_C_LOW  = 4'h5;
   localparam logic [3:0] OFF_TRACE_HIGH = 4'h6;
   localparam logic [3:0] OFF_TRACE_LOW  = 4'h7;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [7:0] RST_CMP_A_LOW  = 8'h00;
   localparam logic [7:0] RST_CMP_B_HIGH = 8'h00;
   localparam logic [7:0] RST_CMP_B_LOW  = 8'h00;
   localparam logic [7:0] RST_CMP_C_HIGH = 8'h00;
   localparam logic [7:0] RST_CMP_C_LOW  = 8'h00;
   localparam logic [7:0] ZERO_BYTE      = 8'h00;

   // ------------------------------------------------------------
   // Trace storage
   // ------------------------------------------------------------
   localparam int         FIFO_DEPTH  = 8;
   localparam int         PTR_W       = 3;
   localparam logic [2:0] PTR_ONE     = 3'h1;
   localparam logic [3:0] CNT_ONE     = 4'h1;
   localparam logic [3:0] CNT_FULL    = 4'h8;

   // Reset handling: normal reset vs. retained end-trace reset
   typedef enum logic [1:0] {
      HOLD_IDLE   = 2'b00,
      HOLD_ARMED  = 2'b01,
      HOLD_KEPT   = 2'b11
   } hold_state_t;

endpackage : dbg_cmp_pkg

// ===== src/debug_compare_and_trace_read.sv
// Compare registers, comparators and trace read port of the on-chip debug unit
//
// The implementer's own choice: the plain strobed port.

// Notes on behaviour
// RULE1 - A low byte matches address bits 7:0
// RULE2 - B high matches address 15:8; ignored full
// RULE3 - B low matches data in full mode
// RULE4 - C high matches address bits 15:8
// RULE5 - C low matches address bits 7:0
// RULE6 - Stored bit equals required bus level
// RULE7 - End-trace reset keeps register contents
// RULE8 - Trace high returns word bits 15:8
// RULE9 - Event-only modes read trace high zero
// RULE10 - Trace low read advances the pointers
// RULE11 - Reader takes high byte before low
// RULE12 - Event-only reader may read low only
// RULE13 - Full: A address, B data; dual: addresses
// RULE14 - Comparators off during debug commands
// RULE15 - Writes to trace bytes change nothing
module debug_compare_and_trace_read (
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst,
   // Register port
   input  wire logic [3:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_write,
   input  wire logic        reg_read,
   output      logic [7:0]  reg_rdata,
   // Unit configuration from control registers outside this block
   input  wire logic        trace_unit_enable,
   input  wire logic        trace_begin_select,
   input  wire logic        full_mode,
   input  wire logic        event_only_mode,
   input  wire logic        cmp_a_high_in,
   input  wire logic [7:0]  cmp_a_match_high,
   // Processor buses
   input  wire logic [15:0] cpu_addr,
   input  wire logic [7:0]  cpu_data,
   input  wire logic        bdm_cmd_active,
   // Trace capture
   input  wire logic        trace_wr_valid,
   input  wire logic [15:0] trace_wr_word,
   // Comparator results and trace word count
   output      logic        match_a,
   output      logic        match_b,
   output      logic        match_c,
   output      logic [3:0]  trace_count
);

   // ------------------------------------------------------------
   // Reset retention
   // ------------------------------------------------------------
   // A reset must be seen before it acts, so the end-trace choice is
   // latched every cycle while out of reset; the async reset itself only
   // clears the visible registers and outputs, never the retained data.
   logic [7:0]  cmp_a_match_low_reg;
   logic [7:0]  cmp_b_match_high_reg;
   logic [7:0]  cmp_b_match_low_reg;
   logic [7:0]  cmp_c_match_high_reg;
   logic [7:0]  cmp_c_match_low_reg;
   logic        end_trace_reg;
   logic        rst_seen_reg;
   logic        keep_reg;
   logic        store_clr_reg;
   logic [7:0]  rdata_reg;
   logic        match_a_reg;
   logic        match_b_reg;
   logic        match_c_reg;
   logic [3:0]  count_reg;

   wire         end_trace_now = trace_unit_enable & ~trace_begin_select;

   // Captures configuration on the clock only; no reset so it survives
   always_ff @(posedge ref_clk) begin
      end_trace_reg <= rst ? end_trace_reg : end_trace_now; // [RULE7]
      rst_seen_reg  <= rst;
   end

   // First edge after release decides whether the values are restored
   always_ff @(posedge ref_clk) begin
      keep_reg <= rst_seen_reg & ~rst & end_trace_reg; // [RULE7]
   end

   // Store clears only on a reset that is not an end-trace reset;
   // an unknown choice at power-up falls to the clearing branch
   always_ff @(posedge ref_clk) begin
      if (rst & end_trace_reg) begin
         store_clr_reg <= 1'b0; // [RULE7]
      end else begin
         store_clr_reg <= rst;
      end
   end

   // ------------------------------------------------------------
   // Register decode
   // ------------------------------------------------------------
   wire wr_a_low  = reg_write & (reg_addr == dbg_cmp_pkg::OFF_CMP_A_LOW);
   wire wr_b_high = reg_write & (reg_addr == dbg_cmp_pkg::OFF_CMP_B_HIGH);
   wire wr_b_low  = reg_write & (reg_addr == dbg_cmp_pkg::OFF_CMP_B_LOW);
   wire wr_c_high = reg_write & (reg_addr == dbg_cmp_pkg::OFF_CMP_C_HIGH);
   wire wr_c_low  = reg_write & (reg_addr == dbg_cmp_pkg::OFF_CMP_C_LOW);
   wire rd_low    = reg_read & (reg_addr == dbg_cmp_pkg::OFF_TRACE_LOW);

   // ------------------------------------------------------------
   // Match registers
   // ------------------------------------------------------------
   // Retained copies live in non-reset shadows; the visible registers
   // take reset values on every reset and reload from them after an end-trace reset ends.
   logic [39:0] shadow_reg;
   wire  [39:0] live_bytes = {cmp_a_match_low_reg, cmp_b_match_high_reg, cmp_b_match_low_reg,
                              cmp_c_match_high_reg, cmp_c_match_low_reg};

   always_ff @(posedge ref_clk) begin
      // Follows the bytes on every edge out of reset except the first after release, so it keeps the pre-reset values
      if (!rst && !rst_seen_reg) begin
         shadow_reg <= live_bytes; // [RULE7]
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cmp_a_match_low_reg  <= dbg_cmp_pkg::RST_CMP_A_LOW;
         cmp_b_match_high_reg <= dbg_cmp_pkg::RST_CMP_B_HIGH;
         cmp_b_match_low_reg  <= dbg_cmp_pkg::RST_CMP_B_LOW;
         cmp_c_match_high_reg <= dbg_cmp_pkg::RST_CMP_C_HIGH;
         cmp_c_match_low_reg  <= dbg_cmp_pkg::RST_CMP_C_LOW;
      end else if (keep_reg) begin
         cmp_a_match_low_reg  <= shadow_reg[39:32]; // [RULE7]
         cmp_b_match_high_reg <= shadow_reg[31:24];
         cmp_b_match_low_reg  <= shadow_reg[23:16];
         cmp_c_match_high_reg <= shadow_reg[15:8];
         cmp_c_match_low_reg  <= shadow_reg[7:0];
      end else begin
         if (wr_a_low) begin
            cmp_a_match_low_reg <= reg_wdata;
         end
         if (wr_b_high) begin
            cmp_b_match_high_reg <= reg_wdata;
         end
         if (wr_b_low) begin
            cmp_b_match_low_reg <= reg_wdata;
         end
         if (wr_c_high) begin
            cmp_c_match_high_reg <= reg_wdata;
         end
         if (wr_c_low) begin
            cmp_c_match_low_reg <= reg_wdata;
         end
      end
   end

   // ------------------------------------------------------------
   // Comparators
   // ------------------------------------------------------------
   wire         cmp_enable = trace_unit_enable & ~bdm_cmd_active; // [RULE14]
   wire [15:0]  a_value = {cmp_a_match_high, cmp_a_match_low_reg}; // [RULE1]
   wire [15:0]  c_value = {cmp_c_match_high_reg, cmp_c_match_low_reg}; // [RULE4] [RULE5]
   // Full mode: B checks the data byte only; high byte forced to agree
   wire [15:0]  b_value = full_mode ? {8'h00, cmp_b_match_low_reg}
                                    : {cmp_b_match_high_reg, cmp_b_match_low_reg}; // [RULE2]
   wire [15:0]  b_bus   = full_mode ? {8'h00, cpu_data} : cpu_addr; // [RULE3] [RULE13]
   wire         hit_a;
   wire         hit_b;
   wire         hit_c;

   addr_matcher u_cmp_a (
      .match_value (a_value),
      .bus_value   (cpu_addr),
      .enable      (cmp_enable),
      .hit         (hit_a)
   );

   addr_matcher u_cmp_b (
      .match_value (b_value),
      .bus_value   (b_bus),
      .enable      (cmp_enable),
      .hit         (hit_b)
   );

   addr_matcher u_cmp_c (
      .match_value (c_value),
      .bus_value   (cpu_addr),
      .enable      (cmp_enable),
      .hit         (hit_c)
   );

   // ------------------------------------------------------------
   // Trace store
   // ------------------------------------------------------------
   wire [15:0] fifo_word;
   wire [3:0]  fifo_count;

   trace_store u_trace (
      .ref_clk    (ref_clk),
      .rst        (store_clr_reg),
      .keep_state (1'b0),
      .wr_valid   (trace_wr_valid),
      .wr_word    (trace_wr_word),
      .rd_advance (rd_low), // [RULE10] [RULE15]
      .rd_word    (fifo_word),
      .count      (fifo_count)
   );

   // ------------------------------------------------------------
   // Read data
   // ------------------------------------------------------------
   wire [7:0] trace_high = event_only_mode ? dbg_cmp_pkg::ZERO_BYTE : fifo_word[15:8]; // [RULE8] [RULE9]
   logic [7:0] rd_mux;

   always_comb begin
      case (reg_addr)
         dbg_cmp_pkg::OFF_CMP_A_LOW:  rd_mux = cmp_a_match_low_reg;
         dbg_cmp_pkg::OFF_CMP_B_HIGH: rd_mux = cmp_b_match_high_reg;
         dbg_cmp_pkg::OFF_CMP_B_LOW:  rd_mux = cmp_b_match_low_reg;
         dbg_cmp_pkg::OFF_CMP_C_HIGH: rd_mux = cmp_c_match_high_reg;
         dbg_cmp_pkg::OFF_CMP_C_LOW:  rd_mux = cmp_c_match_low_reg;
         dbg_cmp_pkg::OFF_TRACE_HIGH: rd_mux = trace_high;
         dbg_cmp_pkg::OFF_TRACE_LOW:  rd_mux = fifo_word[7:0]; // [RULE10]
         default:                     rd_mux = dbg_cmp_pkg::ZERO_BYTE;
      endcase
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rdata_reg   <= dbg_cmp_pkg::ZERO_BYTE;
         match_a_reg <= 1'b0;
         match_b_reg <= 1'b0;
         match_c_reg <= 1'b0;
         count_reg   <= 4'h0;
      end else begin
         rdata_reg   <= reg_read ? rd_mux : dbg_cmp_pkg::ZERO_BYTE;
         match_a_reg <= hit_a;
         match_b_reg <= hit_b;
         match_c_reg <= hit_c;
         count_reg   <= fifo_count;
      end
   end

   assign reg_rdata   = rdata_reg;
   assign match_a     = match_a_reg;
   assign match_b     = match_b_reg;
   assign match_c     = match_c_reg;
   assign trace_count = count_reg;

endmodule : debug_compare_and_trace_read

// ===== src/trace_store.sv
// Eight-word trace store, read pointer advanced by low-byte reads
module trace_store (
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst,
   input  wire logic        keep_state,
   // Capture side
   input  wire logic        wr_valid,
   input  wire logic [15:0] wr_word,
   // Read side
   input  wire logic        rd_advance,
   output      logic [15:0] rd_word,
   output      logic [3:0]  count
);
   logic [15:0] mem [0:dbg_cmp_pkg::FIFO_DEPTH-1];
   logic [2:0]  wr_ptr_reg;
   logic [2:0]  rd_ptr_reg;
   logic [3:0]  cnt_reg;
   wire         do_wr = wr_valid & (cnt_reg != dbg_cmp_pkg::CNT_FULL);
   wire         do_rd = rd_advance & (cnt_reg != 4'h0);

   assign rd_word = mem[rd_ptr_reg];
   assign count   = cnt_reg;

   always_ff @(posedge ref_clk) begin
      if (do_wr) begin
         mem[wr_ptr_reg] <= wr_word;
      end
   end

   // Pointers survive a retained reset so the trace can be read after it
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         wr_ptr_reg <= 3'h0;
         rd_ptr_reg <= 3'h0;
         cnt_reg    <= 4'h0;
      end else if (keep_state) begin
         wr_ptr_reg <= wr_ptr_reg; // [RULE7]
      end else begin
         if (do_wr) begin
            wr_ptr_reg <= wr_ptr_reg + dbg_cmp_pkg::PTR_ONE;
         end
         if (do_rd) begin
            rd_ptr_reg <= rd_ptr_reg + dbg_cmp_pkg::PTR_ONE; // [RULE10]
         end
         if (do_wr && !do_rd) begin
            cnt_reg <= cnt_reg + dbg_cmp_pkg::CNT_ONE;
         end else if (do_rd && !do_wr) begin
            cnt_reg <= cnt_reg - dbg_cmp_pkg::CNT_ONE;
         end
      end
   end
endmodule : trace_store

// ===== tb/cpu_bus_model.sv
// Partner model: processor address and data buses and trace capture pushes
module cpu_bus_model (
   input  wire logic        ref_clk,
   output      logic [15:0] cpu_addr,
   output      logic [7:0]  cpu_data,
   output      logic        trace_wr_valid,
   output      logic [15:0] trace_wr_word
);
   timeunit 1ns;
   timeprecision 1ps;
   initial {cpu_addr, cpu_data, trace_wr_valid, trace_wr_word} = '0;
   // Bus shows the inverse after a cycle, so a stale value never matches by luck
   task automatic bus_cycle(input logic [15:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      cpu_addr <= a;
      cpu_data <= d;
      @(posedge ref_clk);
      cpu_addr <= ~a;
      cpu_data <= ~d;
   endtask : bus_cycle
   task automatic push(input logic [15:0] w);
      @(posedge ref_clk);
      trace_wr_valid <= 1'b1;
      trace_wr_word  <= w;
      @(posedge ref_clk);
      trace_wr_valid <= 1'b0;
      trace_wr_word  <= ~w;
   endtask : push
endmodule : cpu_bus_model

// ===== tb/dbg_cmp_checker.sv
// Checker: timing properties on the ports of the compare and trace read block
module dbg_cmp_checker (
   // Clock and reset
   input wire logic        ref_clk,
   input wire logic        rst,
   // Register port
   input wire logic [3:0]  reg_addr,
   input wire logic [7:0]  reg_wdata,
   input wire logic        reg_write,
   input wire logic        reg_read,
   input wire logic [7:0]  reg_rdata,
   // Configuration and buses
   input wire logic        trace_unit_enable,
   input wire logic        trace_begin_select,
   input wire logic        full_mode,
   input wire logic        event_only_mode,
   input wire logic [7:0]  cmp_a_match_high,
   input wire logic [15:0] cpu_addr,
   input wire logic [7:0]  cpu_data,
   input wire logic        bdm_cmd_active,
   input wire logic        trace_wr_valid,
   // Results
   input wire logic        match_a,
   input wire logic        match_b,
   input wire logic        match_c,
   input wire logic [3:0]  trace_count
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------
   // Shadow of the compare bytes
   // ----------------------------------------
   logic [5:1][7:0] sh_reg;
   logic            keep_reg;
   logic [2:0]      age_reg;
   wire             settled = age_reg >= 3'h4;
   wire             live    = trace_unit_enable && !bdm_cmd_active;
   wire             exp_a   = live && cpu_addr == {cmp_a_match_high, sh_reg[1]};
   wire             exp_b   = live && (full_mode ? cpu_data == sh_reg[3] : cpu_addr == {sh_reg[2], sh_reg[3]});
   wire             exp_c   = live && cpu_addr == {sh_reg[4], sh_reg[5]};
   wire             low_rd  = reg_read && reg_addr == dbg_cmp_pkg::OFF_TRACE_LOW;
   wire             quiet   = !trace_wr_valid && !low_rd;
   wire             cmp_adr = reg_addr inside {[4'h1:4'h5]};
   wire [7:0]       sh_rd   = cmp_adr ? sh_reg[reg_addr[2:0]] : 8'h00;
   wire             tr_wr   = reg_write && reg_addr inside {[4'h6:4'h7]};
   // Mode sampled only outside reset, so it survives into the reset pulse
   always_ff @(posedge ref_clk) begin
      if (!rst) keep_reg <= trace_unit_enable && !trace_begin_select;
   end
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         age_reg <= 3'h0;
         if (keep_reg !== 1'b1) sh_reg <= '0;
      end else begin
         if (age_reg != 3'h7) age_reg <= age_reg + 3'h1;
         if (reg_write && cmp_adr) sh_reg[reg_addr[2:0]] <= reg_wdata;
      end
   end
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   a_match_a_addr: assert property (settled |-> match_a == $past(exp_a))
      else $error("match_a differs from expected compare");
   a_match_b_addr: assert property (settled && !$past(full_mode) |-> match_b == $past(exp_b))
      else $error("match_b address compare wrong");
   a_match_b_data: assert property (settled && $past(full_mode) |-> match_b == $past(exp_b))
      else $error("match_b data compare wrong");
   a_match_c_addr: assert property (settled |-> match_c == $past(exp_c))
      else $error("match_c differs from expected compare");
   a_bdm_no_match: assert property (bdm_cmd_active |=> !match_a && !match_b && !match_c)
      else $error("match seen during debug command");
   a_cmp_readback: assert property (settled && reg_read && cmp_adr |=> reg_rdata == $past(sh_rd))
      else $error("compare byte read back wrong");
   a_high_zero: assert property (reg_read && reg_addr == dbg_cmp_pkg::OFF_TRACE_HIGH && event_only_mode
      |=> reg_rdata == 8'h00)
      else $error("trace high not zero in event-only mode");
   a_low_advance: assert property (settled && quiet ##1 low_rd && !trace_wr_valid && trace_count != 4'h0
      |=> ##1 trace_count == $past(trace_count, 2) - 4'h1)
      else $error("low byte read did not advance store");
   a_trace_wr_none: assert property (settled && quiet ##1 tr_wr && !trace_wr_valid
      |=> ##1 trace_count == $past(trace_count, 2))
      else $error("write to trace byte changed store");
   c_full_hit: cover property (full_mode && match_b);
   c_low_read: cover property (low_rd && trace_count != 4'h0);
   c_kept_read: cover property (settled && keep_reg && reg_read && cmp_adr);
endmodule : dbg_cmp_checker

// ===== tb/tb_top.sv
// Testbench: register, compare, trace read and retained-reset scenarios
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        ref_clk, rst, reg_write, reg_read, match_a, match_b, match_c, trace_wr_valid;
   logic        trace_unit_enable, trace_begin_select, full_mode, event_only_mode, bdm_cmd_active;
   logic        rd_pend = 1'b0;
   logic [3:0]  reg_addr, trace_count;
   logic [7:0]  reg_wdata, reg_rdata, cmp_a_match_high, cpu_data;
   logic [15:0] cpu_addr, trace_wr_word;
   logic [7:0]  exp_q[$];
   logic [7:0]  regs [0:5];
   logic [15:0] words [0:8];
   logic [31:0] seed = 32'h2850_fb9c;
   int          n_errors = 0;
   int          total_checks = 0;
   debug_compare_and_trace_read u_debug_compare_and_trace_read (
      .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
      .reg_read(reg_read), .reg_rdata(reg_rdata), .trace_unit_enable(trace_unit_enable),
      .trace_begin_select(trace_begin_select), .full_mode(full_mode), .event_only_mode(event_only_mode),
      .cmp_a_high_in(1'b0), .cmp_a_match_high(cmp_a_match_high), .cpu_addr(cpu_addr), .cpu_data(cpu_data),
      .bdm_cmd_active(bdm_cmd_active), .trace_wr_valid(trace_wr_valid), .trace_wr_word(trace_wr_word),
      .match_a(match_a), .match_b(match_b), .match_c(match_c), .trace_count(trace_count));
   cpu_bus_model u_cpu_bus_model (.ref_clk(ref_clk), .cpu_addr(cpu_addr), .cpu_data(cpu_data),
      .trace_wr_valid(trace_wr_valid), .trace_wr_word(trace_wr_word));
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // One bus cycle; for a read, d is the value the monitor expects back
   task automatic op(input logic w, input logic r, input logic [3:0] a, input logic [7:0] d);
      reg_write <= w;
      reg_read  <= r;
      reg_addr  <= a;
      reg_wdata <= d;
      if (r) exp_q.push_back(d);
      @(posedge ref_clk);
   endtask : op
   task automatic read_all(input logic kept);
      for (int i = 0; i < 16; i++)
         if (i < 6 || i > 7) op(1'b0, 1'b1, 4'(i), (kept && i < 6) ? regs[i] : 8'h00);
      repeat (3) op(1'b0, 1'b0, 4'h0, 8'h00);
   endtask : read_all
   task automatic do_reset(input int n);
      rst <= 1'b1;
      repeat (n) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (3) @(posedge ref_clk);
   endtask : do_reset
   task automatic wrap_up();
      $display("checks %0d, errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : wrap_up
   // ----------------------------------------
   // Clock, monitor, watchdog
   // ----------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) begin
      if (rd_pend) check(reg_rdata, exp_q.pop_front());
      rd_pend <= reg_read && !rst;
   end
   initial begin
      repeat (4000) @(posedge ref_clk);
      n_errors++;
      wrap_up();
   end
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial begin
      {reg_write, reg_read, trace_unit_enable, trace_begin_select, full_mode, event_only_mode} = '0;
      {bdm_cmd_active, reg_addr, reg_wdata, cmp_a_match_high} = '0;
      regs[0] = 8'h00;
      rst = 1'b1;
      do_reset(20);
      read_all(1'b0);
      for (int i = 1; i < 6; i++) begin
         regs[i] = 8'(rnd());
         op(1'b1, 1'b0, 4'(i), regs[i]);
      end
      for (int i = 0; i < 9; i++) op(1'b1, 1'b0, 4'(i > 0 ? i + 5 : 0), 8'(rnd()));
      read_all(1'b1);
      trace_unit_enable <= 1'b1;
      cmp_a_match_high  <= 8'(rnd());
      op(1'b0, 1'b0, 4'h0, 8'h00);
      u_cpu_bus_model.bus_cycle({cmp_a_match_high, regs[1]}, 8'(rnd()));
      u_cpu_bus_model.bus_cycle({regs[2], regs[3]}, 8'(rnd()));
      u_cpu_bus_model.bus_cycle({regs[4], regs[5]}, 8'(rnd()));
      full_mode <= 1'b1;
      u_cpu_bus_model.bus_cycle({regs[2], ~regs[3]}, regs[3]);
      bdm_cmd_active <= 1'b1;
      u_cpu_bus_model.bus_cycle({regs[4], regs[5]}, regs[3]);
      bdm_cmd_active <= 1'b0;
      full_mode      <= 1'b0;
      // Nine pushes into an eight-word store; the last one is dropped
      for (int k = 0; k < 9; k++) begin
         words[k] = 16'(rnd());
         u_cpu_bus_model.push(words[k]);
      end
      op(1'b1, 1'b0, dbg_cmp_pkg::OFF_TRACE_HIGH, 8'hff);
      op(1'b0, 1'b0, 4'h0, 8'h00);
      op(1'b1, 1'b0, dbg_cmp_pkg::OFF_TRACE_LOW, 8'hff);
      repeat (3) op(1'b0, 1'b0, 4'h0, 8'h00);
      check({4'h0, trace_count}, 8'h08);
      for (int k = 0; k < 8; k++) begin
         event_only_mode <= (k > 3);
         if (k < 6) op(1'b0, 1'b1, dbg_cmp_pkg::OFF_TRACE_HIGH, k > 3 ? 8'h00 : words[k][15:8]);
         op(1'b0, 1'b1, dbg_cmp_pkg::OFF_TRACE_LOW, words[k][7:0]);
      end
      repeat (3) op(1'b0, 1'b0, 4'h0, 8'h00);
      check({4'h0, trace_count}, 8'h00);
      do_reset(2);
      read_all(1'b1);
      trace_unit_enable <= 1'b0;
      op(1'b0, 1'b0, 4'h0, 8'h00);
      do_reset(2);
      read_all(1'b0);
      wrap_up();
   end
endmodule : tb_top

bind debug_compare_and_trace_read dbg_cmp_checker u_dbg_cmp_checker (
   .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
   .reg_read(reg_read), .reg_rdata(reg_rdata), .trace_unit_enable(trace_unit_enable),
   .trace_begin_select(trace_begin_select), .full_mode(full_mode), .event_only_mode(event_only_mode),
   .cmp_a_match_high(cmp_a_match_high), .cpu_addr(cpu_addr), .cpu_data(cpu_data),
   .bdm_cmd_active(bdm_cmd_active), .trace_wr_valid(trace_wr_valid), .match_a(match_a),
   .match_b(match_b), .match_c(match_c), .trace_count(trace_count));
